// ### core/dwp_device.sv
// dram controller end: wait extension, ras precharge, bank mapping, refresh counter
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R1] wait_extend_in adds one or two rising edges
// [R2] extra rising edges precede the falling half
// [R3] extension applies to page beats too
// [R4] host may hold or vary wait_extend_in
// [R5] precharge enforced between accesses and refreshes
// [R6] precharge code selects precharge and refresh low
// [R7] host holds request through inserted waits
// [R8] one independent precharge counter per ras
// [R9] count starts at ending edge, ras after
// [R10] refresh precharge from access end, ras3 end
// [R11] config code, bank, cas enables pick groups
// [R12] all-cas mode: enables gate byte cas
// [R13] code 110: all cas, one ras
// [R14] codes 000, 011: one bank, all lines
// [R15] codes 111, 010: four banks, one each
// [R16] codes 101, 001: two banks, two each
// [R17] host leaves one idle cycle between banks
// [R18] pipelining lets several access ras overlap
// [R19] cas pulses per column in page mode
// [R20] scrubbing systems may hold enables fixed
// [R21] stagger plus scrub splits refresh counter
// [R22] ack style selects polarity of ready pin
// [R23] programming held; counters start satisfied
module dwp_device import dwp_pkg::*; (
  // clock and control
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // link to the host
  dwp_if.dev              lnk,
  // user side status
  output logic            test_mode,
  output logic [NRAS-1:0] ras_active
);

  typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_RLOW} dwp_state_t;

  dwp_state_t      state_q;
  dwp_prog_t       prog_q;
  logic [NRAS-1:0] ras_q;
  logic [NRAS-1:0] cas_q;
  logic [NRAS-1:0] prech_rdy;
  logic [NRAS-1:0] prech_start;
  logic [WCW-1:0]  wcnt_q;
  logic [WCW-1:0]  wtarget;
  logic            rdy_q;
  logic            rdy_half_q;
  logic            rdy_out;
  logic [CNTW-1:0] rcnt_q;
  logic [REFW-1:0] rfc_q;
  logic            cas_any_q;
  logic [7:0]      map;
  logic [NRAS-1:0] ras_sel;
  logic [NRAS-1:0] cas_sel;
  logic            grp_ok;
  logic            all_ok;
  logic            pipe_ok;
  logic            scrub;
  logic            acc_go;
  logic            acc_end;
  logic            pipe_add;
  logic            page_restart;
  logic            page_drop;
  logic            rf_go;
  logic            rf_end;

  ////////////////////////////////////////////////////////////////////////////
  // bank mapping
  // returns {ras group, cas group}
  function automatic logic [7:0] bank_map(input logic [2:0] cfg, input logic [1:0] bank,
                                          input logic [3:0] cen);
    logic [3:0] one;
    logic [3:0] two;
    one = 4'h1 << bank;
    two = bank[0] ? 4'hC : 4'h3;
    case (cfg)
      CFG_ALLCAS:               bank_map = {one, cen};              // [R12] [R13]
      CFG_FOUR, CFG_FOUR_SCRUB: bank_map = {one, one & {4{|cen}}};  // [R15]
      CFG_TWO, CFG_TWO_SCRUB:   bank_map = {two, two & cen};        // [R16]
      default:                  bank_map = {4'hF, cen};             // [R14]
    endcase
  endfunction

  // live decode of the current request; enables are whatever the host holds [R20]
  assign map     = bank_map(prog_q.bank_cfg, lnk.bank_select, lnk.cas_enable_in); // [R11]
  assign ras_sel = map[7:4];
  assign cas_sel = map[3:0];
  assign pipe_ok = (prog_q.bank_cfg == CFG_FOUR) || (prog_q.bank_cfg == CFG_FOUR_SCRUB) ||
                   (prog_q.bank_cfg == CFG_TWO) || (prog_q.bank_cfg == CFG_TWO_SCRUB);
  assign scrub   = (prog_q.bank_cfg == CFG_ONE_SCRUB) || (prog_q.bank_cfg == CFG_TWO_SCRUB) ||
                   (prog_q.bank_cfg == CFG_FOUR_SCRUB);
  assign test_mode = scrub & prog_q.stagger;                        // [R21]

  ////////////////////////////////////////////////////////////////////////////
  // precharge gating: only the lines about to assert need to be ready
  assign grp_ok = &(prech_rdy | ~ras_sel);                          // [R8]
  assign all_ok = &prech_rdy;                                       // [R10]

  // refresh wins over a waiting access; the access simply keeps waiting
  assign rf_go   = (state_q == ST_IDLE) && lnk.refresh_req && all_ok;                 // [R5] [R10]
  assign acc_go  = (state_q == ST_IDLE) && !rf_go && lnk.access_request && grp_ok;    // [R5]
  assign acc_end = (state_q == ST_ACC) && !lnk.access_request;                        // [R9]
  assign pipe_add = (state_q == ST_ACC) && lnk.access_request && lnk.address_strobe_in &&
                    pipe_ok && grp_ok && ((ras_sel & ~ras_q) != 4'h0);                // [R18]
  assign rf_end  = (state_q == ST_RLOW) &&
                   ({1'b0, rcnt_q} >= ({1'b0, RLOW_EDGES[prog_q.prech_sel]} + {3'h0, prog_q.stagger}));

  // page beats: enables released drops ready, enables back restarts the wait
  assign page_drop    = (state_q == ST_ACC) && lnk.access_request && rdy_q && !(|lnk.cas_enable_in);
  assign page_restart = (state_q == ST_ACC) && lnk.access_request && !cas_any_q &&
                        (|lnk.cas_enable_in);                       // [R19] [R3]

  ////////////////////////////////////////////////////////////////////////////
  // programming latch, held until the next load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_q <= '0;
    end else if (ce && lnk.prog_load) begin
      prog_q <= lnk.prog_word;                                      // [R23]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      case (state_q)
        ST_IDLE: begin
          if (rf_go) begin
            state_q <= ST_RLOW;
          end else if (acc_go) begin
            state_q <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (acc_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_RLOW: begin
          if (rf_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ras drive: access group, pipelined additions, refresh groups
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ras_q <= '0;
    end else if (ce) begin
      if (rf_go) begin
        ras_q <= prog_q.stagger ? 4'h3 : 4'hF;  // staggered: upper pair one edge later
      end else if (rf_end || acc_end) begin
        ras_q <= '0;                            // [R10]
      end else if (state_q == ST_RLOW) begin
        ras_q <= 4'hF;
      end else if (acc_go) begin
        ras_q <= ras_sel;                       // [R11]
      end else if (pipe_add) begin
        ras_q <= ras_q | ras_sel;               // [R18]
      end
    end
  end

  // refresh low-time edge count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rcnt_q <= '0;
    end else if (ce) begin
      if (rf_go) begin
        rcnt_q <= CNTW'(1);
      end else if (state_q == ST_RLOW && rcnt_q != CNT_SAT) begin
        rcnt_q <= rcnt_q + CNTW'(1);            // [R6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cas follows the enables each cycle of an access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cas_q     <= '0;
      cas_any_q <= 1'b0;
    end else if (ce) begin
      cas_any_q <= |lnk.cas_enable_in;
      if ((state_q == ST_ACC && !acc_end) || acc_go) begin
        cas_q <= cas_sel;                       // [R19]
      end else begin
        cas_q <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // precharge counters, one per ras line
  genvar gi;
  generate
    for (gi = 0; gi < NRAS; gi++) begin : g_prech
      assign prech_start[gi] = (acc_end && ras_q[gi]) || rf_end;  // [R9] [R10]
      dwp_prech_cnt u_cnt (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .start  (prech_start[gi]),
        .target (PRECH_EDGES[prog_q.prech_sel]),                   // [R6]
        .ready  (prech_rdy[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // wait edge counter; extension is sampled every edge so the host may vary it
  assign wtarget = {1'b0, WAIT_EDGES[prog_q.wait_sel]} +
                   (lnk.wait_extend_in ? (prog_q.ext_two ? EXT_TWO : EXT_ONE) : 4'h0); // [R1]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wcnt_q <= '0;
      rdy_q  <= 1'b0;
    end else if (ce) begin
      if (acc_go || pipe_add || page_restart) begin
        wcnt_q <= '0;                           // [R3]
        rdy_q  <= 1'b0;
      end else if (acc_end || page_drop) begin
        wcnt_q <= '0;
        rdy_q  <= 1'b0;
      end else if (state_q == ST_ACC && !rdy_q) begin
        wcnt_q <= wcnt_q + WCW'(1);
        rdy_q  <= ((wcnt_q + WCW'(1)) >= wtarget); // [R1]
      end
    end
  end

  // falling-level half: only after the rising-edge count is met
  always_ff @(negedge clk) begin
    if (!rst_n) begin
      rdy_half_q <= 1'b0;
    end else if (ce) begin
      rdy_half_q <= rdy_q;                      // [R2]
    end
  end

  assign rdy_out = prog_q.wait_half ? rdy_half_q : rdy_q; // [R2]

  // idle pin is high in both styles; the host rides this to stretch its request [R7]
  assign lnk.transfer_ack_out_n = !lnk.access_request ? 1'b1 :
                                  (prog_q.ack_style ? !rdy_out : rdy_out); // [R22]

  ////////////////////////////////////////////////////////////////////////////
  // refresh address counter; test mode splits it to shorten test time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rfc_q <= '0;
    end else if (ce && rf_end) begin
      if (test_mode) begin
        rfc_q[REF_LO_W-1:0]    <= rfc_q[REF_LO_W-1:0] + REF_LO_W'(1);   // [R21]
        rfc_q[REFW-1:REF_LO_W] <= rfc_q[REFW-1:REF_LO_W] + REF_HI_W'(1);
      end else begin
        rfc_q <= rfc_q + REFW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops except the ready pin
  assign lnk.ras_n         = ~ras_q;
  assign lnk.cas_n         = ~cas_q;
  assign lnk.refresh_busy  = (state_q == ST_RLOW);
  assign lnk.refresh_count = rfc_q;
  assign ras_active        = ras_q;

endmodule
`default_nettype wire

// ### core/dwp_pkg.sv
// shared constants and types for the dram wait, precharge and bank-map block
package dwp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NRAS     = 4;
  localparam int REFW     = 24;
  localparam int REF_LO_W = 13;
  localparam int REF_HI_W = 11;
  localparam int CNTW     = 3;
  localparam int WCW      = 4;
  localparam int REGAW    = 4;
  localparam int DW       = 32;

  ////////////////////////////////////////////////////////////////////////////
  // timing tables indexed by programming codes, in clk rising edges
  localparam logic [2:0] PRECH_EDGES [4] = '{3'h2, 3'h2, 3'h3, 3'h3};
  localparam logic [2:0] RLOW_EDGES  [4] = '{3'h2, 3'h3, 3'h3, 3'h4};
  localparam logic [2:0] WAIT_EDGES  [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  localparam logic [3:0] EXT_ONE         = 4'h1;
  localparam logic [3:0] EXT_TWO         = 4'h2;
  localparam logic [CNTW-1:0] CNT_SAT    = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // bank configuration codes, c6 c5 c4
  localparam logic [2:0] CFG_ONE_SCRUB  = 3'h0;
  localparam logic [2:0] CFG_TWO_SCRUB  = 3'h1;
  localparam logic [2:0] CFG_FOUR_SCRUB = 3'h2;
  localparam logic [2:0] CFG_ONE        = 3'h3;
  localparam logic [2:0] CFG_TWO        = 3'h5;
  localparam logic [2:0] CFG_ALLCAS     = 3'h6;
  localparam logic [2:0] CFG_FOUR       = 3'h7;

  // programming word latched at mode load
  typedef struct packed {
    logic [1:0] prech_sel;
    logic [1:0] wait_sel;
    logic       wait_half;
    logic       ext_two;
    logic       ack_style;
    logic [2:0] bank_cfg;
    logic       stagger;
  } dwp_prog_t;
  localparam int PROGW = 11;

  ////////////////////////////////////////////////////////////////////////////
  // host register map and fields
  localparam logic [REGAW-1:0] REG_PROG = 4'h0;
  localparam logic [REGAW-1:0] REG_ACC  = 4'h1;
  localparam logic [REGAW-1:0] REG_REFR = 4'h2;
  localparam logic [REGAW-1:0] REG_STAT = 4'h3;
  localparam logic [REGAW-1:0] REG_RCNT = 4'h4;
  localparam int ACC_BANK = 0;
  localparam int ACC_CEN  = 2;
  localparam int ACC_WR   = 6;
  localparam int ACC_EXT  = 7;
  localparam int ACC_BEAT = 9;
  localparam logic [1:0] EXT_OFF   = 2'h0;
  localparam logic [1:0] EXT_ON    = 2'h1;
  localparam logic [1:0] EXT_BY_RD = 2'h2;

endpackage

// ### core/dwp_if.sv
// link between the host end and the dram controller end
`timescale 1ns/100ps
`default_nettype none
interface dwp_if import dwp_pkg::*; (
  input wire logic clk
);
  dwp_prog_t             prog_word;
  logic                  prog_load;
  logic                  access_request;
  logic                  address_strobe_in;
  logic [1:0]            bank_select;
  logic [3:0]            cas_enable_in;
  logic                  wait_extend_in;
  logic                  refresh_req;
  logic                  transfer_ack_out_n;
  logic [NRAS-1:0]       ras_n;
  logic [NRAS-1:0]       cas_n;
  logic                  refresh_busy;
  logic [REFW-1:0]       refresh_count;

  modport dev (
    input  prog_word, prog_load, access_request, address_strobe_in, bank_select,
           cas_enable_in, wait_extend_in, refresh_req,
    output transfer_ack_out_n, ras_n, cas_n, refresh_busy, refresh_count
  );
  modport host (
    output prog_word, prog_load, access_request, address_strobe_in, bank_select,
           cas_enable_in, wait_extend_in, refresh_req,
    input  transfer_ack_out_n, ras_n, cas_n, refresh_busy, refresh_count
  );
endinterface
`default_nettype wire

// ### core/dwp_prech_cnt.sv
// per-ras precharge edge counter
`timescale 1ns/100ps
`default_nettype none
module dwp_prech_cnt import dwp_pkg::*; (
  // clock and control
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  // count control
  input  wire logic            start,
  input  wire logic [CNTW-1:0] target,
  // precharge met
  output logic                 ready
);
  logic [CNTW-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // the ending edge is count one; saturates at the target
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= CNT_SAT;                      // satisfied after reset [R23]
    end else if (ce) begin
      if (start) begin
        cnt_q <= CNTW'(1);                   // [R9]
      end else if (cnt_q < target) begin
        cnt_q <= cnt_q + CNTW'(1);
      end
    end
  end

  assign ready = (cnt_q >= target);          // [R9]
endmodule
`default_nettype wire

// ### core/dwp_host.sv
// host end: register port to software, drives the controller link
`timescale 1ns/100ps
`default_nettype none
module dwp_host import dwp_pkg::*; (
  // clock and control
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // software register port
  input  wire logic [REGAW-1:0] addr,
  input  wire logic [DW-1:0]    wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic [DW-1:0]         rdata,
  // link to the controller
  dwp_if.host                   lnk
);

  typedef enum logic [1:0] {H_IDLE, H_REQ, H_GAPCAS, H_END} dwp_hstate_t;

  dwp_hstate_t hst_q;
  dwp_prog_t   prog_q;
  logic        load_q;
  logic [9:0]  acc_q;
  logic [2:0]  beats_q;
  logic        rfq_q;
  logic        done_q;
  logic        ready_seen;
  logic        start;

  assign start = ce && wr && (addr == REG_ACC) && (hst_q == H_IDLE);
  // pin reads ready high in wait style, low in ack style [R22]
  assign ready_seen = prog_q.ack_style ? !lnk.transfer_ack_out_n : lnk.transfer_ack_out_n;

  ////////////////////////////////////////////////////////////////////////////
  // programming and refresh request registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_q <= '0;
      load_q <= 1'b0;
      rfq_q  <= 1'b0;
    end else if (ce) begin
      load_q <= wr && (addr == REG_PROG);
      if (wr && addr == REG_PROG) begin
        prog_q <= wdata[PROGW-1:0];
      end
      // a new request wins over the busy-clear
      if (wr && addr == REG_REFR) begin
        rfq_q <= 1'b1;
      end else if (lnk.refresh_busy) begin
        rfq_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer: hold request until ready, optional page beats, idle gap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hst_q   <= H_IDLE;
      acc_q   <= '0;
      beats_q <= '0;
      done_q  <= 1'b0;
    end else if (ce) begin
      if (wr && addr == REG_STAT) begin
        done_q <= 1'b0;
      end
      case (hst_q)
        H_IDLE: begin
          if (start) begin
            acc_q   <= wdata[9:0];
            beats_q <= wdata[ACC_BEAT+2:ACC_BEAT];
            hst_q   <= H_REQ;
          end
        end
        H_REQ: begin
          if (ready_seen && beats_q != 3'h0) begin
            beats_q <= beats_q - 3'h1;
            hst_q   <= H_GAPCAS;                // [R19]
          end else if (ready_seen) begin
            hst_q <= H_END;                     // [R7]
          end
        end
        H_GAPCAS: hst_q <= H_REQ;
        H_END: begin
          done_q <= 1'b1;
          hst_q  <= H_IDLE;                     // [R17]
        end
        default: hst_q <= H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link drive
  assign lnk.prog_word         = prog_q;
  assign lnk.prog_load         = load_q;
  assign lnk.access_request    = (hst_q == H_REQ) || (hst_q == H_GAPCAS); // [R7]
  assign lnk.address_strobe_in = 1'b0;
  assign lnk.bank_select       = acc_q[ACC_BANK+1:ACC_BANK];
  assign lnk.cas_enable_in     = (hst_q == H_REQ) ? acc_q[ACC_CEN+3:ACC_CEN] : 4'h0; // [R19]
  assign lnk.refresh_req       = rfq_q;
  // extension held, off, or driven from the inverted write flag [R4]
  assign lnk.wait_extend_in    = (acc_q[ACC_EXT+1:ACC_EXT] == EXT_ON) ||
                                 ((acc_q[ACC_EXT+1:ACC_EXT] == EXT_BY_RD) && !acc_q[ACC_WR]);

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce && rd) begin
      case (addr)
        REG_PROG: rdata <= {21'h0, prog_q};
        REG_ACC:  rdata <= {22'h0, acc_q};
        REG_STAT: rdata <= {24'h0, lnk.ras_n, lnk.refresh_busy, rfq_q, done_q, hst_q != H_IDLE};
        REG_RCNT: rdata <= {8'h0, lnk.refresh_count};
        default:  rdata <= '0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### sim/dwp_props.sv
// link checks between the host end and the controller end
`timescale 1ns/100ps
`default_nettype none
module dwp_props import dwp_pkg::*; (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // host side
  input wire dwp_prog_t  prog_word,
  input wire logic       access_request,
  input wire logic [3:0] cas_enable_in,
  input wire logic       wait_extend_in,
  // controller side
  input wire logic       transfer_ack_out_n,
  input wire logic [3:0] ras_n,
  input wire logic [3:0] cas_n,
  input wire logic       refresh_busy
);
  logic [2:0] grp;

  // ras lines one access pulls low, by bank code
  always_comb begin
    case (prog_word.bank_cfg)
      CFG_ALLCAS, CFG_FOUR, CFG_FOUR_SCRUB: grp = 3'h1;
      CFG_TWO, CFG_TWO_SCRUB: grp = 3'h2;
      default: grp = 3'h4;
    endcase
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // first cycle of an access; refresh edges excluded
  sequence s_go;
    access_request && !refresh_busy && !$past(refresh_busy) && $past(ras_n) == 4'hF && ras_n != 4'hF;
  endsequence

  property p_idle;
    !access_request |-> transfer_ack_out_n;
  endproperty
  a_idle: assert property (p_idle) else $error("ready pin active without request");

  property p_busy;
    refresh_busy && access_request |-> transfer_ack_out_n == prog_word.ack_style;
  endproperty
  a_busy: assert property (p_busy) else $error("access not held off by refresh");

  // each ras line counts its own precharge
  for (genvar i = 0; i < 4; i++) begin : g_pre
    property p_gap;
      $rose(ras_n[i]) |=> ras_n[i] ##1 (ras_n[i] || !prog_word.prech_sel[1]);
    endproperty
    a_gap: assert property (p_gap) else $error("precharge cut short");
  end

  property p_rlow;
    !access_request && ras_n == 4'h0 && $past(ras_n) == 4'hF |=> ras_n == 4'h0;
  endproperty
  a_rlow: assert property (p_rlow) else $error("refresh ras low too short");

  property p_ext;
    s_go ##0 (wait_extend_in && !prog_word.ack_style && prog_word.wait_sel != 2'h0) |-> !transfer_ack_out_n [*2];
  endproperty
  a_ext: assert property (p_ext) else $error("extended wait ended early");

  property p_grp;
    s_go |-> $countones(~ras_n) == grp;
  endproperty
  a_grp: assert property (p_grp) else $error("wrong ras group size");

  property p_cas;
    s_go ##0 prog_word.bank_cfg == CFG_ALLCAS |-> cas_n == ~$past(cas_enable_in);
  endproperty
  a_cas: assert property (p_cas) else $error("byte cas not gated");

  property p_page;
    access_request && cas_enable_in == 4'h0 && !prog_word.ack_style ##1 access_request |-> !transfer_ack_out_n;
  endproperty
  a_page: assert property (p_page) else $error("ready kept between beats");
endmodule
`default_nettype wire

// ### sim/dwp_tb_top.sv
// self-checking bench joining the host end and the controller end
`timescale 1ns/100ps
`default_nettype none
module dwp_tb_top import dwp_pkg::*; ;
  typedef struct packed {
    logic [2:0] cfg;
    logic [1:0] bank;
    logic [3:0] cen;
    logic [3:0] ras;
    logic [3:0] cas;
  } dwp_row_t;
  typedef struct packed {
    logic [1:0] ws;
    logic       e2;
    logic       ack;
    logic [1:0] ext;
    logic       w;
  } dwp_wrow_t;
  // code, bank, enables, ras low, cas low
  localparam dwp_row_t ROWS [8] = '{
    '{3'h6, 2'h2, 4'hF, 4'h4, 4'hF}, '{3'h6, 2'h1, 4'h5, 4'h2, 4'h5},
    '{3'h7, 2'h3, 4'hF, 4'h8, 4'h8}, '{3'h2, 2'h0, 4'h1, 4'h1, 4'h1},
    '{3'h5, 2'h1, 4'hF, 4'hC, 4'hC}, '{3'h1, 2'h0, 4'h3, 4'h3, 4'h3},
    '{3'h3, 2'h2, 4'hF, 4'hF, 4'hF}, '{3'h0, 2'h0, 4'h6, 4'hF, 4'h6}};
  // wait select, two edges, ack style, extension mode, write
  localparam dwp_wrow_t WROWS [6] = '{
    '{2'h1, 1'h0, 1'h0, EXT_OFF, 1'h0}, '{2'h1, 1'h0, 1'h0, EXT_ON, 1'h0},
    '{2'h1, 1'h1, 1'h0, EXT_ON, 1'h1}, '{2'h1, 1'h0, 1'h0, EXT_BY_RD, 1'h1},
    '{2'h1, 1'h0, 1'h0, EXT_BY_RD, 1'h0}, '{2'h3, 1'h0, 1'h1, EXT_ON, 1'h0}};

  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [31:0] rdata;
  logic        test_mode;
  logic [3:0]  ras_active;
  int          bad_count = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  ////////////////////////////////////////
  dwp_if lnk_i (.clk(clk));
  dwp_host dwp_host_i (.clk(clk), .rst_n(rst_n), .ce(1'h1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .lnk(lnk_i));
  dwp_device dwp_device_i (.clk(clk), .rst_n(rst_n), .ce(1'h1), .lnk(lnk_i), .test_mode(test_mode),
    .ras_active(ras_active));
  dwp_props dwp_props_i (.clk(clk), .rst_n(rst_n), .prog_word(lnk_i.prog_word),
    .access_request(lnk_i.access_request), .cas_enable_in(lnk_i.cas_enable_in),
    .wait_extend_in(lnk_i.wait_extend_in), .transfer_ack_out_n(lnk_i.transfer_ack_out_n),
    .ras_n(lnk_i.ras_n), .cas_n(lnk_i.cas_n), .refresh_busy(lnk_i.refresh_busy));

  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one settled cycle; a hang ends the run
  task automatic step(inout int n);
    @(posedge clk);
    #1;
    n++;
    if (n > 300) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask
  function automatic logic [31:0] mk(logic [1:0] pre, ws, logic e2, ack, logic [2:0] cfg, logic stg);
    return {21'h0, pre, ws, 1'h0, e2, ack, cfg, stg};
  endfunction
  function automatic logic [31:0] acc(logic [2:0] bt, logic [1:0] ext, logic w, logic [3:0] cen, logic [1:0] bk);
    return {20'h0, bt, ext, w, cen, bk};
  endfunction
  // program, then wait until the controller has it
  task automatic set_prog(input logic [31:0] p);
    int n;
    n = 0;
    wr_reg(REG_PROG, p);
    while (lnk_i.prog_word !== p[10:0]) step(n);
    step(n);
    step(n);
  endtask
  // one access: ras and cas seen at start, cycles from ras to ready; host holds request
  task automatic do_acc(input logic [31:0] d, input logic rdy, output logic [3:0] rl, cl, output int dly);
    int n;
    n = 0;
    dly = 0;
    wr_reg(REG_ACC, d);
    while (lnk_i.ras_n === 4'hF) step(n);
    rl = ~lnk_i.ras_n;
    cl = ~lnk_i.cas_n;
    chk("ras_active", 32'(ras_active), 32'(rl));
    while (lnk_i.transfer_ack_out_n !== rdy) step(dly);
    while (lnk_i.ras_n !== 4'hF) step(n);
  endtask
  // one refresh; low time of the last ras to drop
  task automatic do_ref(output int low);
    int n;
    n = 0;
    low = 0;
    wr_reg(REG_REFR, 32'h1);
    while (lnk_i.ras_n[3] !== 1'h0) step(n);
    while (lnk_i.ras_n[3] !== 1'h1) step(low);
    while (lnk_i.refresh_busy !== 1'h0) step(n);
  endtask

  ////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [3:0]  rl, cl;
    int          d0, d, la, lb, x;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    rd_reg(REG_STAT, v);
    chk("stat", v, 32'hF0);
    rd_reg(4'hF, v);
    chk("unmapped", v, 32'h0);
    foreach (ROWS[k]) begin
      set_prog(mk(2'h0, 2'h0, 1'h0, 1'h0, ROWS[k].cfg, 1'h0));
      do_acc(acc(3'h0, EXT_OFF, 1'h0, ROWS[k].cen, ROWS[k].bank), 1'h1, rl, cl, d);
      chk("ras", 32'(rl), 32'(ROWS[k].ras));
      chk("cas", 32'(cl), 32'(ROWS[k].cas));
    end
    // absolute ready time is the designer's; only the added edges are fixed
    set_prog(mk(2'h0, 2'h0, 1'h0, 1'h0, CFG_FOUR, 1'h0));
    do_acc(acc(3'h0, EXT_OFF, 1'h0, 4'hF, 2'h0), 1'h1, rl, cl, d0);
    foreach (WROWS[k]) begin
      set_prog(mk(2'h0, WROWS[k].ws, WROWS[k].e2, WROWS[k].ack, CFG_FOUR, 1'h0));
      do_acc(acc(3'h0, WROWS[k].ext, WROWS[k].w, 4'hF, 2'(k)), !WROWS[k].ack, rl, cl, d);
      x = (WROWS[k].ext == EXT_ON || (WROWS[k].ext == EXT_BY_RD && !WROWS[k].w)) ? 1 + WROWS[k].e2 : 0;
      chk("wait", d - d0, WAIT_EDGES[WROWS[k].ws] - WAIT_EDGES[0] + x);
    end
    set_prog(mk(2'h0, 2'h0, 1'h0, 1'h0, CFG_FOUR, 1'h0));
    do_acc(acc(3'h2, EXT_ON, 1'h0, 4'hF, 2'h1), 1'h1, rl, cl, d);
    chk("beat wait", d - d0, 32'h1);
    do_ref(la);
    set_prog(mk(2'h3, 2'h0, 1'h0, 1'h0, CFG_ONE, 1'h0));
    do_ref(lb);
    chk("refresh low", lb - la, RLOW_EDGES[3] - RLOW_EDGES[0]);
    for (int c = 0; c < 8; c++) begin
      for (int s = 0; s < 2; s++) begin
        set_prog(mk(2'h0, 2'h0, 1'h0, 1'h0, 3'(c), 1'(s)));
        chk("test mode", 32'(test_mode), 32'(s == 1 && c < 3));
      end
    end
    set_prog(mk(2'h0, 2'h0, 1'h0, 1'h0, CFG_ONE_SCRUB, 1'h1));
    do_ref(la);
    rd_reg(REG_RCNT, v);
    chk("split count", v, 32'h2003);
    // reset in mid-run clears counts and programming
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd_reg(REG_RCNT, v);
    chk("count", v, 32'h0);
    do_acc(acc(3'h0, EXT_OFF, 1'h0, 4'hF, 2'h0), 1'h1, rl, cl, d);
    chk("ras", 32'(rl), 32'hF);
    print_verdict();
  end
endmodule
`default_nettype wire
